//--- bench/interrupt_service_sequencer_tb.sv
// Self-checking bench for the interrupt service sequencer
module interrupt_service_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // -----------------------------------------------------------------
  // Signals and bench model state
  // -----------------------------------------------------------------
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, insn_start, i_flag;
  logic        software_break_instruction, return_from_service_instruction;
  logic [22:0] src_evt;
  logic [3:0]  ext_pin;
  logic [15:0] pc_in, pc_out, mem_addr;
  logic [7:0]  psr_in, psr_out, mem_rdata, mem_wdata;
  logic        cpu_hold, pc_load, psr_load, mem_ready, mem_rd, mem_wr;
  logic        err;
  integer      seed = 89177;
  int          fail_count = 0;
  int          checks_done = 0;
  int          sp = 255;
  int          exp_req = 0;
  logic [15:0] stk_pc [$];
  logic [7:0]  stk_psr [$];

  interrupt_service_sequencer u_dut (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .src_evt, .ext_pin,
    .insn_start, .software_break_instruction, .return_from_service_instruction,
    .pc_in, .psr_in, .cpu_hold, .pc_load, .pc_out, .psr_load, .psr_out, .i_flag,
    .mem_ready, .mem_rdata, .mem_rd, .mem_wr, .mem_addr, .mem_wdata);

  mem_model u_mem (.pclk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_ready,
    .mem_rdata);

  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Vector word as the memory model lays it out
  function automatic logic [15:0] vec(logic [15:0] a);
    return {(a[7:0] + 8'h01) ^ 8'h3c, a[7:0] ^ 8'h3c};
  endfunction

  // Bounded wait; a pulse is seen as sampled at the edge
  task automatic wait_pulse(logic sel);
    int n;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      if (n > 300)
      begin
        fail_count++;
        wrap_up();
      end
    end while ((sel ? psr_load : pc_load) !== 1'b1);
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
      if (n > 50)
      begin
        fail_count++;
        wrap_up();
      end
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    // Let an edge pass so a following call never reassigns psel at once
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Poll point that must start an entry to vector v
  task automatic enter(logic b, logic [15:0] v);
    logic [15:0] pc;
    logic [7:0]  ps;
    pc = $random(seed);
    ps = $random(seed);
    pc_in                      <= pc;
    psr_in                     <= ps;
    software_break_instruction <= b;
    insn_start                 <= 1'b1;
    @(posedge pclk);
    insn_start                 <= 1'b0;
    software_break_instruction <= 1'b0;
    wait_pulse(1'b0);
    chk("vector", vec(v), pc_out);
    chk("push pch", pc[15:8], u_mem.mem[16'h0100 + sp]);
    chk("push pcl", pc[7:0], u_mem.mem[16'h00ff + sp]);
    chk("push psr", ps, u_mem.mem[16'h00fe + sp]);
    chk("inhibit", 1'b1, i_flag);
    sp -= 3;
    stk_pc.push_back(pc);
    stk_psr.push_back(ps);
    $display("test entry %h done", v);
  endtask

  // Return: status first, then the resume address
  task automatic leave;
    insn_start                      <= 1'b1;
    return_from_service_instruction <= 1'b1;
    @(posedge pclk);
    insn_start                      <= 1'b0;
    return_from_service_instruction <= 1'b0;
    wait_pulse(1'b1);
    chk("status", stk_psr.pop_back() & 8'hfb, psr_out);
    wait_pulse(1'b0);
    chk("resume", stk_pc.pop_back(), pc_out);
    chk("inhibit off", 1'b0, i_flag);
    sp += 3;
    $display("test return done");
  endtask

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, insn_start} = 5'h00;
    {software_break_instruction, return_from_service_instruction} = 2'h0;
    {paddr, pwdata, src_evt, ext_pin, pc_in, psr_in} = 0;
    ce = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_pulse(1'b0);
    chk("reset vector", vec(16'hfffa), pc_out);
    chk("inhibit at reset", 1'b1, i_flag);
    @(posedge pclk);
    apb(1'b0, service_pkg::EN_OFF, 0);
    chk("enable reset", 0, rd);
    apb(1'b0, service_pkg::POL_OFF, 0);
    chk("polarity reset", 4'hf, rd);
    apb(1'b0, 12'h040, 0);
    chk("unmapped error", 1'b1, err);
    chk("unmapped data", 0, rd);
    $display("test registers done");
    // Rising edge on ext1 and one-cycle events on 18, 21, 22
    ext_pin <= 4'h2;
    src_evt <= 23'h640000;
    exp_req = 32'h640008;
    @(posedge pclk);
    src_evt <= 0;
    repeat (5) @(posedge pclk);
    apb(1'b1, service_pkg::REQ_OFF, 32'h7fffff);
    apb(1'b0, service_pkg::REQ_OFF, 0);
    chk("request set", exp_req, rd);
    apb(1'b1, service_pkg::REQ_OFF, 32'h7ffff7);
    exp_req &= ~8;
    apb(1'b0, service_pkg::REQ_OFF, 0);
    chk("request cleared", exp_req, rd);
    apb(1'b1, service_pkg::EN_OFF, 32'h7fffff);
    insn_start <= 1'b1;
    @(posedge pclk);
    insn_start <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("masked by inhibit", 1'b0, cpu_hold);
    apb(1'b1, service_pkg::CTRL_OFF, 0);
    repeat (3) @(posedge pclk);
    chk("no poll no entry", 1'b0, cpu_hold);
    enter(1'b0, service_pkg::VEC_COUNTER_PIN_ONE_EVENT);
    exp_req &= ~32'h40000;
    apb(1'b0, service_pkg::REQ_OFF, 0);
    chk("serviced cleared", exp_req, rd);
    apb(1'b0, service_pkg::SP_OFF, 0);
    chk("stack pointer", sp, rd);
    insn_start <= 1'b1;
    @(posedge pclk);
    insn_start <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("nested refused", 1'b0, cpu_hold);
    enter(1'b1, 16'hffca);
    leave();
    enter(1'b0, service_pkg::VEC_OBE);
    leave();
    enter(1'b0, service_pkg::VEC_KEY);
    leave();
    leave();
    apb(1'b0, service_pkg::SP_OFF, 0);
    chk("stack restored", 8'hff, rd);
    apb(1'b0, service_pkg::REQ_OFF, 0);
    chk("all serviced", 0, rd);
    // Falling edge on ext1 once its polarity bit is cleared
    apb(1'b1, service_pkg::POL_OFF, 32'hd);
    ext_pin <= 4'h0;
    repeat (6) @(posedge pclk);
    apb(1'b0, service_pkg::REQ_OFF, 0);
    chk("falling edge", 32'h8, rd);
    $display("test polarity done");
    wrap_up();
  end
endmodule

//--- bench/mem_model.sv
// Stack and vector memory model at the sequencer's memory port
module mem_model (
  // Clock
  input  wire logic        pclk,
  // Memory port
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_ready,
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // -----------------------------------------------------------------
  // Storage, filled with an address-derived pattern
  // -----------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [7:0] junk_q;
  integer     seed = 89177;

  // Vector words are the pattern, so every source has its own target
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0] ^ 8'h3c;
    mem_ready = 1'b0;
    junk_q    = 8'h00;
  end

  // -----------------------------------------------------------------
  // Write on ready, random stalls, scrambled data outside reads
  // -----------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (mem_wr && mem_ready)
      mem[mem_addr] <= mem_wdata;
    mem_ready <= ($random(seed) & 3) != 0;
    junk_q    <= $random(seed);
  end

  // A stale byte must never look like a good read
  assign mem_rdata = mem_rd ? mem[mem_addr] : junk_q;
endmodule

//--- include/service_pkg.sv
// Shared constants for the interrupt service sequencer
package service_pkg;

  // -------------------------------------------------------------------
  // Source counts and priority layout
  // -------------------------------------------------------------------
  localparam int unsigned NUM_SRC         = 23;
  localparam int unsigned NUM_EXT         = 4;
  localparam logic [4:0]  FIRST_MASK_PRIO = 5'h04;
  localparam logic [4:0]  RESET_PRIO      = 5'h03;
  localparam logic [4:0]  BREAK_PRIO      = 5'h1b;
  // Source index of each external pin (ext0, ext1, counter 0, counter 1)
  localparam logic [19:0] EXT_MAP         = {5'h12, 5'h11, 5'h03, 5'h02};

  // -------------------------------------------------------------------
  // Vector table: low byte at even address, high byte one above
  // -------------------------------------------------------------------
  localparam logic [15:0] VEC_TOP         = 16'hfffe;
  localparam logic [15:0] VEC_RESET       = 16'hfffa;
  localparam logic [15:0] VEC_COUNTER_PIN_ONE_EVENT       = 16'hffd4;
  localparam logic [15:0] VEC_OBE         = 16'hffce;
  localparam logic [15:0] VEC_KEY         = 16'hffcc;

  // -------------------------------------------------------------------
  // Stack and status layout
  // -------------------------------------------------------------------
  localparam logic [7:0]  STACK_PAGE      = 8'h01;
  localparam logic [7:0]  SP_RESET        = 8'hff;
  localparam int unsigned PSR_I_BIT       = 2;

  // -------------------------------------------------------------------
  // Register map (byte addresses)
  // -------------------------------------------------------------------
  localparam logic [11:0] REQ_OFF         = 12'h000;
  localparam logic [11:0] EN_OFF          = 12'h004;
  localparam logic [11:0] POL_OFF         = 12'h008;
  localparam logic [11:0] CTRL_OFF        = 12'h00c;
  localparam logic [11:0] SP_OFF          = 12'h010;
  localparam logic [11:0] STAT_OFF        = 12'h014;
  localparam logic [22:0] EN_RESET        = 23'h000000;
  localparam logic [3:0]  POL_RESET       = 4'hf;

  // -------------------------------------------------------------------
  // Service latency window in instruction cycles
  // -------------------------------------------------------------------
  localparam int unsigned LAT_MIN_CYC     = 7;
  localparam int unsigned LAT_MAX_CYC     = 23;

endpackage

//--- logic/interrupt_service_sequencer.sv
// Interrupt polling, entry and return sequencing with APB registers
// What this block does
// - pending requests are sampled only at each instruction start pulse
// - maskable service needs request bit, enable bit set and inhibit flag clear
// - with inhibit set only break or user reset can start service
// - event to routine start takes 7 to 23 instruction cycles
// - service suspends the stream; return resumes at the next instruction
// - entry pushes program counter high, program counter low, then status
// - each push writes at stack pointer, then decrements it by one
// - entry sets the inhibit flag
// - entry clears the serviced source's request bit by hardware
// - after pushes program counter loads from the source's vector
// - return pops status, program counter low, program counter high
// - restoring status on return clears the inhibit flag
// - counter pin one event is priority 22, vector ffd4/ffd5
// - host output buffer empty event is priority 25, vector ffce/ffcf
// - key-on wake-up is lowest priority 26, vector ffcc/ffcd, top bit
// - request sets on event, clears on service or software zero write
// - 23 maskable sources plus software break and non-maskable reset vector
// - polarity bit per external input selects its triggering edge
module interrupt_service_sequencer #(
  parameter int unsigned N = service_pkg::NUM_SRC
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Event sources
  input  wire logic [N-1:0] src_evt,
  input  wire logic [3:0]   ext_pin,
  // CPU instruction sequencer
  input  wire logic        insn_start,
  input  wire logic        software_break_instruction,
  input  wire logic        return_from_service_instruction,
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  psr_in,
  output logic             cpu_hold,
  output logic             pc_load,
  output logic      [15:0] pc_out,
  output logic             psr_load,
  output logic      [7:0]  psr_out,
  output logic             i_flag,
  // Memory port for stack and vector accesses
  input  wire logic        mem_ready,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata
);

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_PUSH_PCH = 4'h1,
    ST_PUSH_PCL = 4'h2,
    ST_PUSH_PSR = 4'h3,
    ST_VEC_LO   = 4'h4,
    ST_VEC_HI   = 4'h5,
    ST_POP_PSR  = 4'h6,
    ST_POP_PCL  = 4'h7,
    ST_POP_PCH  = 4'h8
  } state_t;

  typedef struct packed {
    state_t      st;
    logic [4:0]  src;
    logic [15:0] pc_save;
    logic [7:0]  psr_save;
    logic [7:0]  sp;
    logic        ifl;
    logic [N-1:0] en;
    logic [3:0]  pol;
    logic [15:0] vec_addr;
    logic [7:0]  lo_byte;
    logic        mem_rd;
    logic        mem_wr;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        hold;
    logic        pc_load;
    logic [15:0] pc_out;
    logic        psr_load;
    logic [7:0]  psr_out;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } seq_t;

  seq_t         s_q;
  seq_t         s_d;
  logic [N-1:0] req;
  logic [N-1:0] svc_clr;
  logic         sw_req_wr;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------

  // Vector low address falls by two per priority step
  function automatic logic [15:0] vec_of(input logic [4:0] prio);
    vec_of = service_pkg::VEC_TOP - {10'h000, prio - 5'h01, 1'b0};
  endfunction

  // Lowest set index, which is the smallest priority number
  function automatic logic [4:0] first_set(input logic [N-1:0] v);
    first_set = 5'h00;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        first_set = 5'(i);
      end
    end
  endfunction

  // ---------------------------------------------------------------------
  // Request bits
  // ---------------------------------------------------------------------
  source_request_bank #(
    .N     (N),
    .EXT_N (service_pkg::NUM_EXT)
  ) u_bank (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .evt     (src_evt),
    .ext_pin (ext_pin),
    .pol     (s_q.pol),
    .svc_clr (svc_clr),
    .sw_wr   (sw_req_wr),
    .sw_data (pwdata[N-1:0]),
    .req_q   (req)
  );

  // Request register writes take effect only at the access edge
  assign sw_req_wr = psel && penable && pwrite && s_q.pready
                     && (paddr == service_pkg::REQ_OFF);

  // ---------------------------------------------------------------------
  // Next state: APB, then sequencer, then memory port outputs
  // ---------------------------------------------------------------------
  always_comb
  begin
    logic         setup;
    logic         wr_acc;
    logic [N-1:0] pend;
    s_d = s_q;
    svc_clr = '0;
    setup = psel && !penable;
    wr_acc = psel && penable && pwrite && s_q.pready;
    pend = req & s_q.en;
    s_d.pc_load = 1'b0;
    s_d.psr_load = 1'b0;

    // Zero wait state slave: answer registered in the setup cycle
    s_d.pready = setup;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h00000000;
    if (setup && !pwrite)
    begin
      unique case (paddr)
        service_pkg::REQ_OFF:  s_d.prdata = {9'h000, req};
        service_pkg::EN_OFF:   s_d.prdata = {9'h000, s_q.en};
        service_pkg::POL_OFF:  s_d.prdata = {28'h0000000, s_q.pol};
        service_pkg::CTRL_OFF: s_d.prdata = {31'h00000000, s_q.ifl};
        service_pkg::SP_OFF:   s_d.prdata = {24'h000000, s_q.sp};
        service_pkg::STAT_OFF: s_d.prdata = {19'h00000, s_q.hold, 3'h0, s_q.src, s_q.st};
        default:               s_d.pslverr = 1'b1;
      endcase
    end
    else if (setup)
    begin
      s_d.pslverr = !(paddr inside {service_pkg::REQ_OFF, service_pkg::EN_OFF,
                                    service_pkg::POL_OFF, service_pkg::CTRL_OFF,
                                    service_pkg::SP_OFF, service_pkg::STAT_OFF});
    end
    if (wr_acc)
    begin
      unique case (paddr)
        service_pkg::EN_OFF:   s_d.en = pwdata[N-1:0];
        service_pkg::POL_OFF:  s_d.pol = pwdata[3:0];
        service_pkg::CTRL_OFF: s_d.ifl = pwdata[0];
        // Moving the stack under a running sequence would corrupt it
        service_pkg::SP_OFF:   s_d.sp = (s_q.st == ST_IDLE) ? pwdata[7:0] : s_q.sp;
        default:               s_d.sp = s_d.sp;
      endcase
    end

    // Sequencer
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (insn_start)
        begin
          if (return_from_service_instruction)
          begin
            s_d.st = ST_POP_PSR;
            s_d.sp = s_q.sp + 8'h01;
            s_d.hold = 1'b1;
          end
          else if (software_break_instruction || (!s_q.ifl && |pend))
          begin
            // Break is not masked by the inhibit flag
            if (software_break_instruction)
            begin
              s_d.vec_addr = vec_of(service_pkg::BREAK_PRIO);
            end
            else
            begin
              s_d.src = first_set(pend);
              svc_clr[first_set(pend)] = 1'b1;
              s_d.vec_addr = vec_of(first_set(pend) + service_pkg::FIRST_MASK_PRIO);
            end
            s_d.pc_save = pc_in;
            s_d.psr_save = psr_in;
            s_d.ifl = 1'b1;
            // Six cycles to pc_load with a ready memory; the CPU adds the rest
            s_d.st = ST_PUSH_PCH;
            s_d.hold = 1'b1;
          end
        end
      end
      ST_PUSH_PCH, ST_PUSH_PCL, ST_PUSH_PSR:
      begin
        if (mem_ready)
        begin
          s_d.sp = s_q.sp - 8'h01;
          s_d.st = state_t'(s_q.st + 4'h1);
        end
      end
      ST_VEC_LO:
      begin
        if (mem_ready)
        begin
          s_d.lo_byte = mem_rdata;
          s_d.st = ST_VEC_HI;
        end
      end
      ST_VEC_HI, ST_POP_PCH:
      begin
        if (mem_ready)
        begin
          s_d.pc_out = {mem_rdata, s_q.lo_byte};
          s_d.pc_load = 1'b1;
          s_d.hold = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      ST_POP_PSR:
      begin
        if (mem_ready)
        begin
          s_d.psr_out = mem_rdata;
          s_d.psr_out[service_pkg::PSR_I_BIT] = 1'b0;
          s_d.psr_load = 1'b1;
          s_d.ifl = 1'b0;
          s_d.sp = s_q.sp + 8'h01;
          s_d.st = ST_POP_PCL;
        end
      end
      ST_POP_PCL:
      begin
        if (mem_ready)
        begin
          s_d.lo_byte = mem_rdata;
          s_d.sp = s_q.sp + 8'h01;
          s_d.st = ST_POP_PCH;
        end
      end
      default:
      begin
        s_d.st = ST_IDLE;
        s_d.hold = 1'b0;
      end
    endcase

    // Memory strobes follow the next state so they leave a flip-flop
    s_d.mem_rd = 1'b0;
    s_d.mem_wr = 1'b0;
    s_d.mem_addr = {service_pkg::STACK_PAGE, s_d.sp};
    s_d.mem_wdata = 8'h00;
    unique case (s_d.st)
      ST_PUSH_PCH:
      begin
        s_d.mem_wr = 1'b1;
        s_d.mem_wdata = s_d.pc_save[15:8];
      end
      ST_PUSH_PCL:
      begin
        s_d.mem_wr = 1'b1;
        s_d.mem_wdata = s_d.pc_save[7:0];
      end
      ST_PUSH_PSR:
      begin
        s_d.mem_wr = 1'b1;
        s_d.mem_wdata = s_d.psr_save;
      end
      ST_VEC_LO:
      begin
        s_d.mem_rd = 1'b1;
        s_d.mem_addr = s_d.vec_addr;
      end
      ST_VEC_HI:
      begin
        s_d.mem_rd = 1'b1;
        s_d.mem_addr = s_d.vec_addr + 16'h0001;
      end
      ST_POP_PSR, ST_POP_PCL, ST_POP_PCH:
      begin
        s_d.mem_rd = 1'b1;
      end
      default:
      begin
        s_d.mem_rd = 1'b0;
      end
    endcase
  end

  // Reset starts the non-maskable reset vector fetch at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.st <= ST_VEC_LO;
      s_q.sp <= service_pkg::SP_RESET;
      s_q.ifl <= 1'b1;
      s_q.en <= service_pkg::EN_RESET;
      s_q.pol <= service_pkg::POL_RESET;
      s_q.vec_addr <= service_pkg::VEC_RESET;
      s_q.mem_rd <= 1'b1;
      s_q.mem_addr <= service_pkg::VEC_RESET;
      s_q.hold <= 1'b1;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign cpu_hold  = s_q.hold;
  assign pc_load   = s_q.pc_load;
  assign pc_out    = s_q.pc_out;
  assign psr_load  = s_q.psr_load;
  assign psr_out   = s_q.psr_out;
  assign i_flag    = s_q.ifl;
  assign mem_rd    = s_q.mem_rd;
  assign mem_wr    = s_q.mem_wr;
  assign mem_addr  = s_q.mem_addr;
  assign mem_wdata = s_q.mem_wdata;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_poll_only;
    @(posedge pclk) disable iff (!presetn)
    (ce && s_q.st == ST_IDLE && !insn_start) |=> s_q.st == ST_IDLE;
  endproperty
  a_poll_only: assert property (p_poll_only) else $error("left idle without poll");

  property p_take;
    @(posedge pclk) disable iff (!presetn)
    (ce && s_q.st == ST_IDLE && insn_start && !return_from_service_instruction
     && !s_q.ifl && |(req & s_q.en)) |=> (s_q.st == ST_PUSH_PCH && s_q.ifl && cpu_hold);
  endproperty
  a_take: assert property (p_take) else $error("enabled request not taken");

  property p_entry_time;
    @(posedge pclk) disable iff (!presetn)
    (ce && s_q.st == ST_IDLE && insn_start && !return_from_service_instruction
     && (software_break_instruction || (!s_q.ifl && |(req & s_q.en))))
    ##1 (ce && mem_ready)[*5] |=> (pc_load && !cpu_hold);
  endproperty
  a_entry_time: assert property (p_entry_time) else $error("entry too slow");

  property p_inhibit;
    @(posedge pclk) disable iff (!presetn)
    (ce && s_q.st == ST_IDLE && s_q.ifl && !software_break_instruction
     && !return_from_service_instruction) |=> s_q.st == ST_IDLE;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("maskable taken while inhibited");

  property p_push_order;
    @(posedge pclk) disable iff (!presetn)
    (ce && s_q.st == ST_PUSH_PCH && mem_ready) |=>
      (s_q.st == ST_PUSH_PCL && mem_wdata == s_q.pc_save[7:0]
       && mem_addr == {service_pkg::STACK_PAGE, $past(s_q.sp) - 8'h01});
  endproperty
  a_push_order: assert property (p_push_order) else $error("push order wrong");

  property p_push_dec;
    @(posedge pclk) disable iff (!presetn)
    (ce && mem_wr && mem_ready) |=> s_q.sp == $past(s_q.sp) - 8'h01;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("stack pointer not decremented");

  property p_svc_clear;
    @(posedge pclk) disable iff (!presetn)
    (|svc_clr) |-> ($onehot(svc_clr) && s_q.st == ST_IDLE && insn_start);
  endproperty
  a_svc_clear: assert property (p_svc_clear) else $error("bad request clear");

  property p_vector;
    @(posedge pclk) disable iff (!presetn)
    (ce && s_q.st == ST_VEC_HI && mem_ready) |=>
      (pc_load && pc_out == {$past(mem_rdata), s_q.lo_byte} && !cpu_hold);
  endproperty
  a_vector: assert property (p_vector) else $error("vector not loaded");

  property p_pop_order;
    @(posedge pclk) disable iff (!presetn)
    (ce && s_q.st == ST_POP_PSR && mem_ready) |=> (s_q.st == ST_POP_PCL && psr_load
      && !i_flag && !psr_out[service_pkg::PSR_I_BIT]);
  endproperty
  a_pop_order: assert property (p_pop_order) else $error("pop order or flag wrong");

  property p_key_vec;
    @(posedge pclk) disable iff (!presetn)
    (s_q.st == ST_VEC_LO && s_q.src == 5'h16 && s_q.vec_addr != service_pkg::VEC_RESET
     && s_q.vec_addr != vec_of(service_pkg::BREAK_PRIO)) |-> mem_addr == service_pkg::VEC_KEY;
  endproperty
  a_key_vec: assert property (p_key_vec) else $error("wake-up vector wrong");

endmodule

//--- logic/source_request_bank.sv
// Sticky request bits with edge-selectable external pin capture
module source_request_bank #(
  parameter int unsigned N     = 23,
  parameter int unsigned EXT_N = 4
) (
  // Clock, reset, enable
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Event sources
  input  wire logic [N-1:0]     evt,
  input  wire logic [EXT_N-1:0] ext_pin,
  input  wire logic [EXT_N-1:0] pol,
  // Clear paths
  input  wire logic [N-1:0]     svc_clr,
  input  wire logic             sw_wr,
  input  wire logic [N-1:0]     sw_data,
  // Request state
  output logic      [N-1:0]     req_q
);

  typedef struct packed {
    logic [EXT_N-1:0] sync1;
    logic [EXT_N-1:0] sync2;
    logic [EXT_N-1:0] prev;
    logic [N-1:0]     req;
  } bank_t;

  bank_t s_q;
  bank_t s_d;

  // Edge detect only on the second sync stage; set beats any clear
  always_comb
  begin
    logic [N-1:0] set;
    logic [N-1:0] clr;
    set = evt;
    clr = svc_clr | (sw_wr ? ~sw_data : '0);
    s_d = s_q;
    s_d.sync1 = ext_pin;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    for (int i = 0; i < EXT_N; i++)
    begin
      if (pol[i] ? (s_q.sync2[i] & ~s_q.prev[i]) : (~s_q.sync2[i] & s_q.prev[i]))
      begin
        set[service_pkg::EXT_MAP[5*i +: 5]] = 1'b1;
      end
    end
    s_d.req = (s_q.req & ~clr) | set;
  end

  // State register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign req_q = s_q.req;

endmodule
